// file: include/dsm_pkg.sv
// Constants and types shared by the data space mapper files
`default_nettype none
package dsm_pkg;
  // Address and data widths
  localparam int EA_W = 16;
  localparam int DATA_W = 16;
  localparam int PM_W = 24;
  localparam int PAGE_W = 8;
  localparam int WIN_LOW_W = 15;
  localparam int PM_ADDR_W = PAGE_W + WIN_LOW_W;
  localparam int WIN_SEL_BIT = 15;
  // Fixed X/Y boundary and extent of physical data memory
  localparam logic [15:0] X_SPACE_END = 16'h0bff;
  localparam logic [15:0] Y_SPACE_START = 16'h0c00;
  localparam logic [15:0] Y_SPACE_END = 16'h0fff;
  // Data returned for an access that may not land
  localparam logic [15:0] ZERO_DATA = 16'h0000;
  // Instruction class codes from the pipeline
  localparam logic [1:0] CLS_OTHER = 2'h0;
  localparam logic [1:0] CLS_DUAL = 2'h1;
  localparam logic [1:0] CLS_MOVE = 2'h2;
  localparam logic [1:0] CLS_DMOVE = 2'h3;
  // Working register numbers of the dedicated pointers
  localparam logic [3:0] PTR_X_A = 4'h8;
  localparam logic [3:0] PTR_X_B = 4'h9;
  localparam logic [3:0] PTR_Y_A = 4'ha;
  localparam logic [3:0] PTR_Y_B = 4'hb;
  // Extra instruction cycles of a windowed read
  localparam logic [1:0] PEN_NONE = 2'h0;
  localparam logic [1:0] PEN_SHORT = 2'h1;
  localparam logic [1:0] PEN_LONG = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WIN, ST_CAP} dsm_state_e;
  // Whole state of the mapper; reset value is all zero
  typedef struct packed {
    dsm_state_e st;
    logic [1:0] cnt;
    logic win;
    logic x_bad;
    logic y_bad;
    logic busy;
    logic rd_valid;
    logic x_rd_en;
    logic [EA_W-1:0] x_rd_addr;
    logic x_wr_en;
    logic [EA_W-1:0] x_wr_addr;
    logic [DATA_W-1:0] x_wr_data;
    logic y_rd_en;
    logic [EA_W-1:0] y_rd_addr;
    logic pm_rd_en;
    logic [PM_ADDR_W-1:0] pm_addr;
    logic [DATA_W-1:0] x_rdata;
    logic [DATA_W-1:0] y_rdata;
  } dsm_regs_s;
endpackage : dsm_pkg
`default_nettype wire

// file: logic/dsm_agen.sv
// Modulo wrap and bit-reversal stage for one effective address path
`timescale 1ns/1ps
`default_nettype none
module dsm_agen
  import dsm_pkg::*;
#(
  parameter int AW = EA_W,
  parameter int BREV_W = 4
) (
  input wire logic [AW-1:0] ea,
  input wire logic mod_en,
  input wire logic [AW-1:0] mod_start,
  input wire logic [AW-1:0] mod_end,
  input wire logic brev_en,
  output logic [AW-1:0] addr
);
  // Buffer length in bytes; end points at the last word
  logic [AW-1:0] len;
  logic [AW-1:0] wrapped;
  logic [AW-1:0] rev;

  assign len = AW'(mod_end - mod_start + AW'(2));

  // Fold an address that stepped past either end back into the buffer
  always_comb begin
    if (mod_en && (ea > mod_end)) begin
      wrapped = AW'(ea - len);
    end else if (mod_en && (ea < mod_start)) begin
      wrapped = AW'(ea + len);
    end else begin
      wrapped = ea;
    end
  end

  // Mirror the low BREV_W word index bits; the byte select bit and the bits above stay put
  assign rev[0] = wrapped[0];
  assign rev[AW-1:BREV_W+1] = wrapped[AW-1:BREV_W+1];
  generate
    for (genvar i = 0; i < BREV_W; i++) begin : g_rev
      assign rev[i+1] = wrapped[BREV_W-i];
    end
  endgenerate

  // Reversal only when the caller asks for it
  assign addr = brev_en ? rev : wrapped;
endmodule : dsm_agen
`default_nettype wire

// file: logic/dsm_mapper.sv
// Data space decode, X/Y bus steering and program space window mapper
//
// Behaviour
// - Upper data half maps onto one program page
// - Window only when EA top bit and enable
// - Windowed read takes a second program fetch, except on middle repeat iterations
// - Windowed read returns low 16 program bits
// - Program address: page register plus 15 EA bits
// - Table instructions suspend the window
// - Outside repeat: multiply, move classes add one
// - Outside repeat: other classes add two cycles
// - Repeat first, last, interrupt edges add two
// - Other repeat iterations add no cycles
// - All writes travel only the X write bus
// - X read bus serves combined space, X operand
// - Modulo on X; bit reversal on X writes
// - Y bus is a read path, multiply only
// - Pointers 10,11 are Y; 8,9 are X
// - Accumulator write-back uses X bus, any X or Y address
// - Y path: prefetch only, with modulo support
// - X/Y boundary fixed in decode
// - Out of space or memory reads zero
// - Upper half decodes as X space only while the window is on and no table instruction runs
// - Effective addresses are 16-bit byte addresses
`timescale 1ns/1ps
`default_nettype none
module dsm_mapper
  import dsm_pkg::*;
#(
  parameter int BREV_W = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_wback,
  input wire logic [1:0] req_class,
  input wire logic [EA_W-1:0] req_x_ea,
  input wire logic [3:0] req_x_ptr,
  input wire logic req_y_en,
  input wire logic [EA_W-1:0] req_y_ea,
  input wire logic [3:0] req_y_ptr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic rpt_active,
  input wire logic rpt_first,
  input wire logic rpt_last,
  input wire logic rpt_irq_exit,
  input wire logic rpt_irq_reenter,
  input wire logic table_active,
  input wire logic window_enable,
  input wire logic [PAGE_W-1:0] window_page,
  input wire logic mod_x_en,
  input wire logic [EA_W-1:0] mod_x_start,
  input wire logic [EA_W-1:0] mod_x_end,
  input wire logic mod_y_en,
  input wire logic [EA_W-1:0] mod_y_start,
  input wire logic [EA_W-1:0] mod_y_end,
  input wire logic brev_en,
  input wire logic [DATA_W-1:0] x_ram_rdata,
  input wire logic [DATA_W-1:0] y_ram_rdata,
  input wire logic [PM_W-1:0] pm_rdata,
  output logic busy,
  output logic rd_valid,
  output logic [DATA_W-1:0] x_rdata,
  output logic [DATA_W-1:0] y_rdata,
  output logic x_rd_en,
  output logic [EA_W-1:0] x_rd_addr,
  output logic x_wr_en,
  output logic [EA_W-1:0] x_wr_addr,
  output logic [DATA_W-1:0] x_wr_data,
  output logic y_rd_en,
  output logic [EA_W-1:0] y_rd_addr,
  output logic pm_rd_en,
  output logic [PM_ADDR_W-1:0] pm_addr
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  dsm_regs_s q; // Registered state
  dsm_regs_s n; // Next state
  logic [EA_W-1:0] x_eff; // X address after modulo and reversal
  logic [EA_W-1:0] y_eff; // Y address after modulo
  logic take; // Request accepted this cycle
  logic is_wr; // Any write, including write-back
  logic is_dual; // Dual-operand multiply class
  logic x_in_x; // X address inside X memory
  logic x_in_y; // X address inside Y memory
  logic win_hit; // Read goes through the window
  logic x_ok; // X operand may be fetched
  logic y_ok; // Y operand may be fetched
  logic [1:0] pen; // Extra cycles for a windowed read

  ////////////////////////////////////////////////////////////////////////
  // Address generation
  // Reversal only ever applies to a write on the X side
  dsm_agen #(.AW(EA_W), .BREV_W(BREV_W)) u_xgen (
    .ea(req_x_ea),
    .mod_en(mod_x_en),
    .mod_start(mod_x_start),
    .mod_end(mod_x_end),
    .brev_en(brev_en && is_wr),
    .addr(x_eff)
  );

  // Y side wraps circular buffers but never reverses
  dsm_agen #(.AW(EA_W), .BREV_W(BREV_W)) u_ygen (
    .ea(req_y_ea),
    .mod_en(mod_y_en),
    .mod_start(mod_y_start),
    .mod_end(mod_y_end),
    .brev_en(1'b0),
    .addr(y_eff)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode
  // Boundaries are package constants, so software cannot move them
  always_comb begin
    take = req_valid && (q.st == ST_IDLE);
    is_wr = req_write || req_wback;
    is_dual = (req_class == CLS_DUAL);
    // Whole 16-bit byte address compared; upper half is never RAM
    x_in_x = !x_eff[WIN_SEL_BIT] && (x_eff <= X_SPACE_END);
    x_in_y = (x_eff >= Y_SPACE_START) && (x_eff <= Y_SPACE_END);
    // Upper half belongs to X and is seen through the window
    win_hit = x_eff[WIN_SEL_BIT] && window_enable
              && !table_active;
    if (is_dual) begin
      // Multiply class X operand needs an X pointer and X space
      x_ok = ((req_x_ptr == PTR_X_A) || (req_x_ptr == PTR_X_B)) &&
             (x_in_x || win_hit);
    end else begin
      // Everything else sees X and Y as one linear space
      x_ok = x_in_x || x_in_y || win_hit;
    end
    // Y operand needs a Y pointer and a Y address
    y_ok = ((req_y_ptr == PTR_Y_A) || (req_y_ptr == PTR_Y_B)) &&
           (y_eff >= Y_SPACE_START) && (y_eff <= Y_SPACE_END);
    // Cost of a windowed read
    if (!rpt_active) begin
      if (req_class != CLS_OTHER) begin
        pen = PEN_SHORT;
      end else begin
        pen = PEN_LONG;
      end
    end else if (rpt_first || rpt_last ||
                 rpt_irq_exit || rpt_irq_reenter) begin
      pen = PEN_LONG;
    end else begin
      pen = PEN_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;
    // Enables and the result strobe are single-cycle pulses, except pm_rd_en, which stays high two cycles on a two-fetch windowed read
    n.x_rd_en = 1'b0;
    n.x_wr_en = 1'b0;
    n.y_rd_en = 1'b0;
    n.pm_rd_en = 1'b0;
    n.rd_valid = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (take && is_wr) begin
          // Writes never stall; the window is read-only, so none lands
          n.x_wr_en = x_in_x || x_in_y;
          n.x_wr_addr = x_eff;
          n.x_wr_data = req_wdata;
        end else if (take) begin
          n.busy = 1'b1;
          n.st = ST_WAIT;
          n.win = win_hit && x_ok;
          n.x_bad = !x_ok;
          n.cnt = (win_hit && x_ok) ? pen : PEN_NONE;
          n.x_rd_en = x_ok && !win_hit;
          n.x_rd_addr = x_eff;
          // First program fetch of a windowed read
          n.pm_rd_en = win_hit && x_ok;
          n.pm_addr = {window_page, x_eff[WIN_LOW_W-1:0]};
          // Y is only a second read path for the multiply class
          n.y_rd_en = is_dual && req_y_en && y_ok;
          n.y_bad = !(is_dual && req_y_en && y_ok);
          n.y_rd_addr = y_eff;
        end
      end
      ST_WAIT: begin
        if (q.win && (q.cnt != PEN_NONE)) begin
          // Second program fetch; its data is what gets returned
          n.pm_rd_en = 1'b1;
          n.st = ST_WIN;
        end else begin
          n.st = ST_CAP;
        end
      end
      ST_WIN: begin
        // Burn the remaining penalty with the pipeline held
        n.cnt = q.cnt - 2'h1;
        if (q.cnt == 2'h1) begin
          n.st = ST_CAP;
        end
      end
      ST_CAP: begin
        // Upper program byte is dropped on a windowed read
        if (q.x_bad) begin
          n.x_rdata = ZERO_DATA;
        end else if (q.win) begin
          n.x_rdata = pm_rdata[DATA_W-1:0];
        end else begin
          n.x_rdata = x_ram_rdata;
        end
        n.y_rdata = q.y_bad ? ZERO_DATA : y_ram_rdata;
        n.rd_valid = 1'b1;
        n.busy = 1'b0;
        n.st = ST_IDLE;
      end
      default: begin
        n.st = ST_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  // Reset to all zero: idle, no enables, results zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register
  assign busy = q.busy;
  assign rd_valid = q.rd_valid;
  assign x_rdata = q.x_rdata;
  assign y_rdata = q.y_rdata;
  assign x_rd_en = q.x_rd_en;
  assign x_rd_addr = q.x_rd_addr;
  assign x_wr_en = q.x_wr_en;
  assign x_wr_addr = q.x_wr_addr;
  assign x_wr_data = q.x_wr_data;
  assign y_rd_en = q.y_rd_en;
  assign y_rd_addr = q.y_rd_addr;
  assign pm_rd_en = q.pm_rd_en;
  assign pm_addr = q.pm_addr;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Windowed read taken, with its cost class
  sequence s_win_rd;
    take && !is_wr && win_hit && x_ok;
  endsequence
  sequence s_short;
    s_win_rd ##0 (!rpt_active && req_class != CLS_OTHER);
  endsequence
  sequence s_long;
    s_win_rd ##0 (!rpt_active && req_class == CLS_OTHER);
  endsequence
  sequence s_rpt_edge;
    s_win_rd ##0 (rpt_active &&
      (rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reenter));
  endsequence
  sequence s_rpt_mid;
    s_win_rd ##0 (rpt_active && !rpt_first && !rpt_last &&
      !rpt_irq_exit && !rpt_irq_reenter);
  endsequence

  a_window_route: assert property (
    s_win_rd |=> pm_rd_en && !x_rd_en)
    else $error("windowed read not routed to program memory");
  a_table_suspend: assert property (
    take && !is_wr && table_active |=> !pm_rd_en)
    else $error("window used during table instruction");
  a_page_addr: assert property (
    s_win_rd |=> pm_addr == {$past(window_page),
                             $past(x_eff[WIN_LOW_W-1:0])})
    else $error("program address not built from page and EA");
  a_short_cost: assert property (
    s_short |-> ##1 (busy && !rd_valid)[*3] ##1 (rd_valid && !busy))
    else $error("short windowed read not one extra cycle");
  a_long_cost: assert property (
    s_long |-> ##1 (!rd_valid)[*4] ##1 rd_valid)
    else $error("windowed read not two extra cycles");
  a_repeat_edge: assert property (
    s_rpt_edge |-> ##1 (!rd_valid)[*4] ##1 rd_valid)
    else $error("repeat edge iteration not two extra cycles");
  a_repeat_mid: assert property (
    s_rpt_mid |-> ##1 (!rd_valid)[*2] ##1 rd_valid)
    else $error("repeat iteration took added cycles");
  a_second_fetch: assert property (
    s_short |-> ##1 pm_rd_en ##1 pm_rd_en)
    else $error("windowed read lacks two program fetches");
  a_low_word: assert property (
    q.st == ST_CAP && q.win && !q.x_bad
      |=> x_rdata == $past(pm_rdata[DATA_W-1:0]))
    else $error("windowed read not low program word");
  a_bad_xptr: assert property (
    take && !is_wr && is_dual && req_x_ptr != PTR_X_A &&
      req_x_ptr != PTR_X_B |-> ##3 rd_valid && x_rdata == ZERO_DATA)
    else $error("multiply fetch by non-X pointer not zero");
  a_y_read_only: assert property (
    y_rd_en |-> $past(take && !is_wr && is_dual))
    else $error("Y bus used outside multiply read");
  a_write_xbus: assert property (
    take && is_wr && (x_in_x || x_in_y) |=>
      x_wr_en && x_wr_data == $past(req_wdata) && !y_rd_en)
    else $error("write not placed on X write bus");
endmodule : dsm_mapper
`default_nettype wire

// file: testbench/dsm_data_space_xy_window_mapper_test.sv
// Self-checking bench for the data space mapper
`timescale 1ns/1ps
`default_nettype none
module dsm_data_space_xy_window_mapper_test
  import dsm_pkg::*;
;
  localparam logic [15:0] XK = 16'h5a5a;
  localparam logic [15:0] YK = 16'h3c3c;
  localparam logic [15:0] PK = 16'h6d29;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic req_valid, req_write, req_wback, req_y_en, rpt_active, rpt_first;
  logic rpt_last, rpt_irq_exit, rpt_irq_reenter, table_active;
  logic window_enable, mod_x_en, mod_y_en, brev_en;
  logic [1:0] req_class;
  logic [3:0] req_x_ptr, req_y_ptr;
  logic [15:0] req_x_ea, req_y_ea, req_wdata, mod_x_start, mod_x_end;
  logic [15:0] mod_y_start, mod_y_end, x_ram_rdata, y_ram_rdata;
  logic [15:0] x_rdata, y_rdata, x_rd_addr, x_wr_addr, x_wr_data, y_rd_addr;
  logic [7:0] window_page;
  logic [23:0] pm_rdata;
  logic [22:0] pm_addr;
  logic busy, rd_valid, x_rd_en, x_wr_en, y_rd_en, pm_rd_en;
  logic last_pm, last_y, last_x;
  int fail_count = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  dsm_mapper dut_u (.*);
  dsm_mem_model #(.XK(XK), .YK(YK), .PK(PK)) mem_u (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Expected low program word for a windowed address
  function automatic logic [15:0] pmw(input logic [15:0] a);
    logic [22:0] p;
    p = {window_page, a[14:0]};
    return p[15:0] ^ PK;
  endfunction : pmw
  // One read: request for one cycle, then time the answer in cycles
  task automatic rd(input logic [1:0] c, input logic [15:0] xa,
    input logic [3:0] xp, input logic ye, input logic [15:0] ya,
    input logic [3:0] yp, input int lat, input logic [15:0] ex, ey);
    int n;
    @(negedge clk_sys);
    {req_class, req_x_ea, req_x_ptr} = {c, xa, xp};
    {req_y_en, req_y_ea, req_y_ptr} = {ye, ya, yp};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    {last_pm, last_y, last_x} = 3'h0;
    chk("busy", 1, busy);
    while (rd_valid !== 1'b1 && n < 9) begin
      last_pm |= pm_rd_en;
      last_y |= y_rd_en;
      last_x |= x_rd_en;
      @(negedge clk_sys);
      n++;
    end
    chk("latency", lat, n);
    chk("busy_end", 0, busy);
    chk("x_rdata", ex, x_rdata);
    chk("y_rdata", ey, y_rdata);
  endtask : rd
  task automatic xr(input logic [1:0] c, input logic [15:0] a,
    input int lat, input logic [15:0] ex);
    rd(c, a, PTR_X_A, 1'b0, 16'h0000, PTR_Y_A, lat, ex, 16'h0000);
  endtask : xr
  // One write; ax is the bus address, en says whether the bus must strobe
  task automatic wr(input logic wb, input logic [15:0] a, d, ax,
    input logic en);
    @(negedge clk_sys);
    {req_write, req_wback, req_x_ea, req_wdata} = {~wb, wb, a, d};
    req_valid = 1'b1;
    @(negedge clk_sys);
    {req_valid, req_write, req_wback} = 3'h0;
    chk("x_wr_en", en, x_wr_en);
    chk("y_rd_en", 0, y_rd_en);
    if (en) begin
      chk("x_wr_addr", ax, x_wr_addr);
      chk("x_wr_data", d, x_wr_data);
    end
  endtask : wr
  ////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    xr(CLS_OTHER, 16'h0100, 3, 16'h0100 ^ XK);
    chk("x_fetch", 1, last_x);
    xr(CLS_MOVE, 16'h0c20, 3, 16'h0c20 ^ XK);
    xr(CLS_OTHER, 16'h1000, 3, 16'h0000);
    xr(CLS_DMOVE, 16'h7ffe, 3, 16'h0000);
  endtask : t_plain
  task automatic t_mac();
    rd(CLS_DUAL, 16'h0200, PTR_X_A, 1'b1, 16'h0c40, PTR_Y_A, 3,
       16'h0200 ^ XK, 16'h0c40 ^ YK);
    chk("y_fetch", 1, last_y);
    rd(CLS_DUAL, 16'h0bfe, PTR_X_B, 1'b1, 16'h0ffe, PTR_Y_B, 3,
       16'h0bfe ^ XK, 16'h0ffe ^ YK);
    rd(CLS_DUAL, 16'h0c00, PTR_X_A, 1'b1, 16'h0100, PTR_Y_A, 3,
       16'h0000, 16'h0000);
    chk("y_fetch", 0, last_y);
    rd(CLS_DUAL, 16'h0300, PTR_Y_A, 1'b1, 16'h0c00, PTR_X_A, 3,
       16'h0000, 16'h0000);
    rd(CLS_OTHER, 16'h0300, PTR_X_A, 1'b1, 16'h0c00, PTR_Y_A, 3,
       16'h0300 ^ XK, 16'h0000);
    chk("y_fetch", 0, last_y);
  endtask : t_mac
  task automatic t_window();
    logic [15:0] a;
    window_enable = 1'b1;
    window_page = 8'h5b;
    for (int c = 0; c < 4; c++) begin
      a = 16'h8000 + 16'(c * 16'h1236);
      xr(2'(c), a, c == 0 ? 5 : 4, pmw(a));
      chk("pm_addr", {9'h000, window_page, a[14:0]}, 32'(pm_addr));
      chk("pm_fetch", 1, last_pm);
      chk("x_fetch", 0, last_x);
    end
    xr(CLS_DUAL, 16'hfffe, 4, pmw(16'hfffe));
    table_active = 1'b1;
    xr(CLS_MOVE, 16'h8000, 3, 16'h0000);
    chk("pm_fetch", 0, last_pm);
    {table_active, window_enable} = 2'h0;
    xr(CLS_MOVE, 16'h8000, 3, 16'h0000);
    chk("pm_fetch", 0, last_pm);
  endtask : t_window
  // Iteration kinds in turn: first, last, exit, re-entry, middle
  task automatic t_repeat();
    logic [15:0] a;
    {window_enable, rpt_active} = 2'h3;
    for (int k = 0; k < 5; k++) begin
      a = 16'h9000 + 16'(k * 2);
      {rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reenter} = 4'(8 >> k);
      xr(CLS_MOVE, a, k < 4 ? 5 : 3, pmw(a));
    end
    {window_enable, rpt_active} = 2'h0;
  endtask : t_repeat
  // Addresses one past the buffer end must wrap to its start
  task automatic t_modulo();
    {mod_x_en, mod_y_en} = 2'h3;
    {mod_x_start, mod_x_end} = {16'h0100, 16'h011e};
    {mod_y_start, mod_y_end} = {16'h0c00, 16'h0c1e};
    rd(CLS_DUAL, 16'h0120, PTR_X_A, 1'b1, 16'h0c20, PTR_Y_A, 3,
       16'h0100 ^ XK, 16'h0c00 ^ YK);
    chk("x_rd_addr", 16'h0100, x_rd_addr);
    chk("y_rd_addr", 16'h0c00, y_rd_addr);
    {mod_x_en, mod_y_en} = 2'h0;
  endtask : t_modulo
  task automatic t_write();
    wr(1'b0, 16'h0200, 16'h1234, 16'h0200, 1'b1);
    wr(1'b1, 16'h0c02, 16'hbeef, 16'h0c02, 1'b1);
    wr(1'b0, 16'h2000, 16'h5555, 16'h2000, 1'b0);
    window_enable = 1'b1;
    wr(1'b1, 16'h8000, 16'haaaa, 16'h8000, 1'b0);
    window_enable = 1'b0;
  endtask : t_write
  // Reversal mirrors the four word index bits of writes, never of reads
  task automatic t_brev();
    brev_en = 1'b1;
    wr(1'b0, 16'h0202, 16'h2468, 16'h0210, 1'b1);
    wr(1'b0, 16'h0316, 16'h1357, 16'h031a, 1'b1);
    xr(CLS_OTHER, 16'h0202, 3, 16'h0202 ^ XK);
    chk("x_rd_addr", 16'h0202, x_rd_addr);
    brev_en = 1'b0;
  endtask : t_brev
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {req_valid, req_write, req_wback, req_y_en, rpt_active, rpt_first,
     rpt_last, rpt_irq_exit, rpt_irq_reenter, table_active} = '0;
    {window_enable, mod_x_en, mod_y_en, brev_en} = '0;
    {req_class, req_x_ptr, req_y_ptr, window_page} = '0;
    {req_x_ea, req_y_ea, req_wdata, mod_x_start, mod_x_end} = '0;
    {mod_y_start, mod_y_end} = '0;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk("rst_busy", 0, busy);
    chk("rst_valid", 0, rd_valid);
    t_plain();
    t_mac();
    t_window();
    t_repeat();
    t_modulo();
    t_write();
    t_brev();
    final_report();
  end
  // Whole run needs about 140 cycles; cut a hang short
  initial begin
    repeat (4000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
endmodule : dsm_data_space_xy_window_mapper_test
`default_nettype wire

// file: testbench/dsm_mem_model.sv
// Data RAM and program memory model behind the mapper
`timescale 1ns/1ps
`default_nettype none
module dsm_mem_model
  import dsm_pkg::*;
#(
  parameter logic [15:0] XK = 16'h5a5a,
  parameter logic [15:0] YK = 16'h3c3c,
  parameter logic [15:0] PK = 16'h6d29
) (
  input wire logic clk_sys,
  input wire logic x_rd_en,
  input wire logic [EA_W-1:0] x_rd_addr,
  input wire logic y_rd_en,
  input wire logic [EA_W-1:0] y_rd_addr,
  input wire logic pm_rd_en,
  input wire logic [PM_ADDR_W-1:0] pm_addr,
  output logic [DATA_W-1:0] x_ram_rdata,
  output logic [DATA_W-1:0] y_ram_rdata,
  output logic [PM_W-1:0] pm_rdata
);
  initial begin
    x_ram_rdata = '0;
    y_ram_rdata = '0;
    pm_rdata = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // RAM word lives one cycle, then flips so a late capture cannot pass
  always @(posedge clk_sys) begin
    x_ram_rdata <= x_rd_en ? x_rd_addr ^ XK : ~x_ram_rdata;
    y_ram_rdata <= y_rd_en ? y_rd_addr ^ YK : ~y_ram_rdata;
    // Program memory holds its word until the next fetch
    if (pm_rd_en) begin
      pm_rdata <= {pm_addr[22:15], pm_addr[15:0] ^ PK};
    end
  end
endmodule : dsm_mem_model
`default_nettype wire
